// File: core/cafet_flags.sv
// Per-channel alarm flags, violation flags and fault tallies on AXI4-Lite
`default_nettype none

module cafet_flags #(
  parameter int NUM_CH       = cafet_pkg::NUM_CH,
  parameter int ROUND_CYCLES = cafet_pkg::ROUND_CYCLES
) (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // AXI4-Lite write address
  input  wire logic [cafet_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output var  logic                          s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output var  logic                          s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]                    s_axi_bresp,
  output var  logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [cafet_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output var  logic                          s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0]                   s_axi_rdata,
  output var  logic [1:0]                    s_axi_rresp,
  output var  logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Detector states, one bit per channel 1..16
  input  wire logic [NUM_CH-1:0]             sys_side_alarm_state,
  input  wire logic [NUM_CH-1:0]             line_side_alarm_state,
  input  wire logic [NUM_CH-1:0]             prbs_sync_state,
  input  wire logic [NUM_CH-1:0]             loop_up_code_state,
  input  wire logic [NUM_CH-1:0]             loop_down_code_state,
  // Detector event pulses, one bit per channel 1..16
  input  wire logic [NUM_CH-1:0]             sys_bpv_event,
  input  wire logic [NUM_CH-1:0]             line_bpv_event,
  input  wire logic [NUM_CH-1:0]             sys_exz_event,
  input  wire logic [NUM_CH-1:0]             line_exz_event,
  input  wire logic [NUM_CH-1:0]             prbs_bit_fault_event,
  // Error pulses to count, bit 0 is channel 0
  input  wire logic [NUM_CH:0]               fault_count_pulse,
  // Interrupts
  output var  logic                          flag_int,
  output var  logic                          irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } cafet_wr_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } cafet_rd_t;

  typedef struct packed {
    logic [NUM_CH-1:0][7:0]           alarm_flag;
    logic [NUM_CH-1:0][7:0]           viol_flag;
    logic [NUM_CH-1:0][4:0]           prev_state;
    logic [NUM_CH:0][7:0]             cfg;
    logic [NUM_CH:0][15:0]            counter;
    logic [NUM_CH:0][15:0]            fault_tally;
    logic [cafet_pkg::IRQ_W-1:0]      irq_status;
    logic [cafet_pkg::IRQ_W-1:0]      irq_mask;
    logic                             flag_int;
    logic                             irq;
    cafet_wr_t                        wr_state;
    logic                             aw_got;
    logic                             w_got;
    logic [cafet_pkg::IDX_W-1:0]      wr_idx;
    logic [7:0]                       wr_byte;
    logic                             wr_lane;
    logic                             awready;
    logic                             wready;
    logic                             bvalid;
    logic [1:0]                       bresp;
    cafet_rd_t                        rd_state;
    logic                             arready;
    logic                             rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
  } cafet_state_t;

  cafet_state_t                  s;
  cafet_state_t                  next_s;
  logic                          round_tick;
  logic [NUM_CH-1:0][7:0]        alarm_set;
  logic [NUM_CH-1:0][7:0]        alarm_clr;
  logic [NUM_CH-1:0][7:0]        viol_set;
  logic [NUM_CH-1:0][7:0]        viol_clr;
  logic [NUM_CH:0]               manual_cap;
  logic [NUM_CH:0]               capture;
  logic [NUM_CH:0]               wrap;
  logic [cafet_pkg::IRQ_W-1:0]   irq_set;
  logic [cafet_pkg::IRQ_W-1:0]   irq_rd_clr;
  logic [4:0]                    cur;
  logic [4:0]                    chg;
  logic [4:0]                    rise;
  logic [15:0]                   cnt_after;
  logic [7:0]                    rd_byte;
  cafet_pkg::cafet_dec_t         wdec;
  cafet_pkg::cafet_dec_t         rdec;
  logic [cafet_pkg::CH_W-1:0]    wfi;
  logic [cafet_pkg::CH_W-1:0]    rfi;

  // ------------------------------------------------------------------
  // Round timer
  // ------------------------------------------------------------------
  cafet_round_timer #(
    .ROUND_CYCLES (ROUND_CYCLES)
  ) u_round_timer (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .round_tick (round_tick)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s     = s;
    alarm_set  = '0;
    alarm_clr  = '0;
    viol_set   = '0;
    viol_clr   = '0;
    manual_cap = '0;
    capture    = '0;
    wrap       = '0;
    irq_set    = '0;
    irq_rd_clr = '0;
    cur        = '0;
    chg        = '0;
    rise       = '0;
    cnt_after  = '0;
    rd_byte    = 8'h00;
    wdec       = cafet_pkg::cafet_decode(s.wr_idx);
    rdec       = cafet_pkg::cafet_decode(
                   s_axi_araddr[cafet_pkg::ADDR_W-1:2]);
    wfi        = wdec.ch - 5'h01;
    rfi        = rdec.ch - 5'h01;

    // Write channel: address and data taken in either order
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.wr_idx = s_axi_awaddr[cafet_pkg::ADDR_W-1:2];
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got   = 1'b1;
      next_s.wr_byte = s_axi_wdata[7:0];
      next_s.wr_lane = s_axi_wstrb[0];
    end
    unique case (s.wr_state)
      WR_IDLE: begin
        if (s.aw_got && s.w_got) begin
          next_s.aw_got   = 1'b0;
          next_s.w_got    = 1'b0;
          next_s.bvalid   = 1'b1;
          next_s.wr_state = WR_RESP;
          next_s.bresp    = wdec.hit ? cafet_pkg::RESP_OKAY
                                     : cafet_pkg::RESP_DECERR;
          if (wdec.hit && s.wr_lane) begin
            unique case (wdec.sel)
              cafet_pkg::SEL_ALARM: begin
                alarm_clr[wfi[3:0]] = s.wr_byte;
              end
              cafet_pkg::SEL_VIOL: begin
                viol_clr[wfi[3:0]] = s.wr_byte;
              end
              cafet_pkg::SEL_CFG: begin
                next_s.cfg[wdec.ch] = s.wr_byte & cafet_pkg::CFG_MASK;
                manual_cap[wdec.ch] = s.wr_byte[cafet_pkg::CAPTURE_BIT];
              end
              cafet_pkg::SEL_IRQ_MASK: begin
                next_s.irq_mask = s.wr_byte[cafet_pkg::IRQ_W-1:0];
              end
              default: begin
              end
            endcase
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_s.bvalid   = 1'b0;
          next_s.wr_state = WR_IDLE;
        end
      end
    endcase
    next_s.awready = !next_s.aw_got && (next_s.wr_state == WR_IDLE);
    next_s.wready  = !next_s.w_got && (next_s.wr_state == WR_IDLE);

    // Read channel, one cycle to data
    unique case (s.rd_state)
      RD_IDLE: begin
        if (s.arready && s_axi_arvalid) begin
          unique case (rdec.sel)
            cafet_pkg::SEL_ALARM:    rd_byte = s.alarm_flag[rfi[3:0]];
            cafet_pkg::SEL_VIOL:     rd_byte = s.viol_flag[rfi[3:0]];
            cafet_pkg::SEL_TALLY_LO: begin
              rd_byte = s.fault_tally[rdec.ch][7:0];
            end
            cafet_pkg::SEL_TALLY_HI: begin
              rd_byte = s.fault_tally[rdec.ch][15:8];
            end
            cafet_pkg::SEL_CFG:      rd_byte = s.cfg[rdec.ch];
            cafet_pkg::SEL_IRQ_ST: begin
              rd_byte    = 8'(s.irq_status);
              irq_rd_clr = s.irq_status;
            end
            cafet_pkg::SEL_IRQ_MASK: rd_byte = 8'(s.irq_mask);
            default:                 rd_byte = 8'h00;
          endcase
          next_s.rdata    = {24'h000000, rd_byte};
          next_s.rresp    = rdec.hit ? cafet_pkg::RESP_OKAY
                                     : cafet_pkg::RESP_DECERR;
          next_s.rvalid   = 1'b1;
          next_s.arready  = 1'b0;
          next_s.rd_state = RD_DATA;
        end else begin
          next_s.arready = 1'b1;
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          next_s.rvalid   = 1'b0;
          next_s.arready  = 1'b1;
          next_s.rd_state = RD_IDLE;
        end
      end
    endcase

    // Fault tallies and rounds
    for (int c = 0; c <= NUM_CH; c++) begin
      capture[c] = manual_cap[c] ||
                   (round_tick && s.cfg[c][cafet_pkg::MODE_BIT]);
      wrap[c]    = fault_count_pulse[c] &&
                   (s.counter[c] == cafet_pkg::TALLY_MAX);
      cnt_after  = (fault_count_pulse[c] && !wrap[c]) ?
                   s.counter[c] + 16'h0001 : s.counter[c];
      if (capture[c]) begin
        next_s.fault_tally[c] = cnt_after;
        next_s.counter[c]     = 16'h0000;
      end else begin
        next_s.counter[c] = cnt_after;
      end
    end

    // Edge detection and flag setting per channel
    for (int c = 0; c < NUM_CH; c++) begin
      cur  = {sys_side_alarm_state[c], line_side_alarm_state[c],
              prbs_sync_state[c], loop_up_code_state[c],
              loop_down_code_state[c]};
      chg  = cur ^ s.prev_state[c];
      rise = cur & ~s.prev_state[c];
      next_s.prev_state[c] = cur;
      alarm_set[c][cafet_pkg::SYS_ALARM_BIT] =
        s.cfg[c+1][cafet_pkg::ALARM_ES_BIT] ? chg[4] : rise[4];
      alarm_set[c][cafet_pkg::LINE_ALARM_BIT] =
        s.cfg[c+1][cafet_pkg::ALARM_ES_BIT] ? chg[3] : rise[3];
      alarm_set[c][cafet_pkg::PRBS_SYNC_BIT] =
        s.cfg[c+1][cafet_pkg::PRBS_ES_BIT] ? chg[2] : rise[2];
      alarm_set[c][cafet_pkg::LOOP_UP_BIT] =
        s.cfg[c+1][cafet_pkg::LOOP_ES_BIT] ? chg[1] : rise[1];
      alarm_set[c][cafet_pkg::LOOP_DOWN_BIT] =
        s.cfg[c+1][cafet_pkg::LOOP_ES_BIT] ? chg[0] : rise[0];
      viol_set[c][cafet_pkg::SYS_BPV_BIT]  = sys_bpv_event[c];
      viol_set[c][cafet_pkg::LINE_BPV_BIT] = line_bpv_event[c];
      viol_set[c][cafet_pkg::SYS_EXZ_BIT]  = sys_exz_event[c];
      viol_set[c][cafet_pkg::LINE_EXZ_BIT] = line_exz_event[c];
      viol_set[c][cafet_pkg::PRBS_ERR_BIT] = prbs_bit_fault_event[c];
      viol_set[c][cafet_pkg::WRAP_BIT]     = wrap[c+1];
      next_s.alarm_flag[c] =
        (s.alarm_flag[c] & ~alarm_clr[c]) | alarm_set[c];
      next_s.viol_flag[c] =
        (s.viol_flag[c] & ~viol_clr[c]) | viol_set[c];
    end

    // Summary interrupt: sticky, cleared by reading, set wins
    irq_set[cafet_pkg::IRQ_ALARM_BIT] = |alarm_set;
    irq_set[cafet_pkg::IRQ_VIOL_BIT]  = |viol_set;
    irq_set[cafet_pkg::IRQ_TALLY_BIT] = |capture;
    next_s.irq_status = (s.irq_status & ~irq_rd_clr) | irq_set;
    next_s.irq        = |(next_s.irq_status & next_s.irq_mask);
    next_s.flag_int   = (|next_s.alarm_flag) ||
                        (|next_s.viol_flag);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;
  assign flag_int      = s.flag_int;
  assign irq           = s.irq;

endmodule // cafet_flags

`default_nettype wire

// File: core/cafet_pkg.sv
// Constants, types and address decoding for the channel flag block
`default_nettype none

package cafet_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int          NUM_CH    = 16;
  localparam int          IDX_W     = 12;
  localparam int          ADDR_W    = 14;
  localparam int          CH_W      = 5;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0]  OFS_ALARM     = 6'h21;
  localparam logic [5:0]  OFS_VIOL      = 6'h22;
  localparam logic [5:0]  OFS_TALLY_LO  = 6'h23;
  localparam logic [5:0]  OFS_TALLY_HI  = 6'h24;
  localparam logic [5:0]  OFS_CFG       = 6'h2A;
  localparam logic [5:0]  OFS_IRQ_ST    = 6'h30;
  localparam logic [5:0]  OFS_IRQ_MASK  = 6'h31;
  localparam logic [5:0]  BLK_CH0       = 6'h1F;
  localparam logic [11:0] IDX_ALARM_CH1 = 12'h021;
  localparam logic [11:0] CH_STRIDE     = 12'h040;
  localparam logic [11:0] IDX_CH0_LO    = 12'h7E3;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int          SYS_ALARM_BIT  = 7;
  localparam int          LINE_ALARM_BIT = 6;
  localparam int          PRBS_SYNC_BIT  = 5;
  localparam int          LOOP_UP_BIT    = 1;
  localparam int          LOOP_DOWN_BIT  = 0;
  localparam int          SYS_BPV_BIT    = 5;
  localparam int          LINE_BPV_BIT   = 4;
  localparam int          SYS_EXZ_BIT    = 3;
  localparam int          LINE_EXZ_BIT   = 2;
  localparam int          PRBS_ERR_BIT   = 1;
  localparam int          WRAP_BIT       = 0;
  localparam int          ALARM_ES_BIT   = 6;
  localparam int          PRBS_ES_BIT    = 5;
  localparam int          LOOP_ES_BIT    = 0;
  localparam int          MODE_BIT       = 1;
  localparam int          CAPTURE_BIT    = 2;
  localparam logic [7:0]  CFG_MASK       = 8'h63;
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_ALARM_BIT  = 0;
  localparam int          IRQ_VIOL_BIT   = 1;
  localparam int          IRQ_TALLY_BIT  = 2;

  // ------------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------------
  localparam logic [7:0]  FLAG_RST       = 8'h00;
  localparam logic [7:0]  TALLY_LO_RST   = 8'h00;
  localparam logic [15:0] TALLY_MAX      = 16'hFFFF;
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          ROUND_MS       = 1000;
  localparam int          ROUND_CYCLES   = (CLK_HZ / 1000) * ROUND_MS;

  // ------------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  typedef enum logic [2:0] {
    SEL_NONE     = 3'h0,
    SEL_ALARM    = 3'h1,
    SEL_VIOL     = 3'h2,
    SEL_TALLY_LO = 3'h3,
    SEL_TALLY_HI = 3'h4,
    SEL_CFG      = 3'h5,
    SEL_IRQ_ST   = 3'h6,
    SEL_IRQ_MASK = 3'h7
  } cafet_sel_t;

  typedef struct packed {
    logic            hit;
    cafet_sel_t      sel;
    logic [CH_W-1:0] ch;
  } cafet_dec_t;

  // Map a register index onto a channel and register
  function automatic cafet_dec_t cafet_decode(input logic [IDX_W-1:0] idx);
    cafet_dec_t d;
    d.hit = 1'b0;
    d.sel = SEL_NONE;
    d.ch  = 5'h00;
    if (idx[11:10] == 2'h0) begin
      d.ch = 5'(idx[9:6]) + 5'h01;
      unique case (idx[5:0])
        OFS_ALARM:    d.sel = SEL_ALARM;
        OFS_VIOL:     d.sel = SEL_VIOL;
        OFS_TALLY_LO: d.sel = SEL_TALLY_LO;
        OFS_TALLY_HI: d.sel = SEL_TALLY_HI;
        OFS_CFG:      d.sel = SEL_CFG;
        default:      d.sel = SEL_NONE;
      endcase
    end else if (idx[11:6] == BLK_CH0) begin
      unique case (idx[5:0])
        OFS_TALLY_LO: d.sel = SEL_TALLY_LO;
        OFS_TALLY_HI: d.sel = SEL_TALLY_HI;
        OFS_CFG:      d.sel = SEL_CFG;
        OFS_IRQ_ST:   d.sel = SEL_IRQ_ST;
        OFS_IRQ_MASK: d.sel = SEL_IRQ_MASK;
        default:      d.sel = SEL_NONE;
      endcase
    end
    d.hit = (d.sel != SEL_NONE);
    return d;
  endfunction

endpackage : cafet_pkg

`default_nettype wire

// File: core/cafet_round_timer.sv
// Counting round timer: one-cycle tick at the end of every round
`default_nettype none

module cafet_round_timer #(
  parameter int ROUND_CYCLES = cafet_pkg::ROUND_CYCLES
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Round end
  output var  logic round_tick
);

  localparam int CNT_W = $clog2(ROUND_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(ROUND_CYCLES - 1);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
  } cafet_timer_t;

  cafet_timer_t s;
  cafet_timer_t next_s;

  // ------------------------------------------------------------------
  // Round counter
  // ------------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.tick = (s.count == LAST);
    if (s.count == LAST) begin
      next_s.count = '0;
    end else begin
      next_s.count = s.count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign round_tick = s.tick;

endmodule // cafet_round_timer

`default_nettype wire

// File: test/cafet_flags_checker.sv
// Bus handshake and flag pin checker for the channel flag block
`default_nettype none

module cafet_flags_checker #(
  parameter int NUM_CH = 16
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  // Register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Detectors and pin
  input wire logic [NUM_CH-1:0] sys_side_alarm_state,
  input wire logic [NUM_CH-1:0] sys_bpv_event,
  input wire logic              flag_int
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_read_answer: assert property (ar_take |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ar_busy: assert property (ar_take |=> !s_axi_arready)
    else $error("arready stayed high");
  a_aw_busy: assert property (wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write readies stayed high");
  a_alarm_pin: assert property ((sys_side_alarm_state &
    ~$past(sys_side_alarm_state)) != '0 |=> flag_int) else $error("no pin");
  a_event_pin: assert property (|sys_bpv_event |=> flag_int)
    else $error("event left pin low");
  a_pin_clear: assert property ($fell(flag_int) |-> $rose(s_axi_bvalid))
    else $error("pin fell without write");
endmodule // cafet_flags_checker

`default_nettype wire

// File: test/tb.sv
// Register level bench for the channel flag block
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int round_len = 50;
  localparam int bit_pos [5] = '{7, 6, 5, 1, 0};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [13:0] s_axi_awaddr = '0;
  logic [13:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, flag_int, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [15:0] st [5] = '{default: '0};
  logic [15:0] ev [5] = '{default: '0};
  logic [16:0] cnt_p = '0;
  logic [7:0] m;
  int err_count = 0;
  int checks = 0;

  always #25 clk_sys = ~clk_sys;

  cafet_flags #(.ROUND_CYCLES(round_len)) dut (
    .clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sys_side_alarm_state(st[0]),
    .line_side_alarm_state(st[1]), .prbs_sync_state(st[2]),
    .loop_up_code_state(st[3]), .loop_down_code_state(st[4]),
    .sys_bpv_event(ev[0]), .line_bpv_event(ev[1]), .sys_exz_event(ev[2]),
    .line_exz_event(ev[3]), .prbs_bit_fault_event(ev[4]),
    .fault_count_pulse(cnt_p), .flag_int, .irq
  );

  // ----------------------------------------
  // Check, wait, bus and finish tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk_sys);
      if (!a && s_axi_awready === 1'b1) begin
        a = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] i);
    @(posedge clk_sys);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wrap_up();
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(12'h022); chk("viol reset", rdat, 32'h0);
    rd(12'h023); chk("tally reset", rdat, 32'h0);
    rd(12'h7E3); chk("ch0 tally reset", rdat, 32'h0);
    for (int p = 0; p < 2; p++) begin
      wr(12'h02A, p ? 8'h61 : 8'h00);
      for (int k = 0; k < 5; k++) begin
        m = 8'h01 << bit_pos[k];
        st[k][0] <= 1'b1;
        cyc(2);
        wr(12'h021, 8'h00);
        rd(12'h021); chk("alarm set", rdat, {24'h0, m});
        chk("flag pin", {31'h0, flag_int}, 32'h1);
        wr(12'h021, m);
        rd(12'h021); chk("alarm clear", rdat, 32'h0);
        chk("pin idle", {31'h0, flag_int}, 32'h0);
        st[k][0] <= 1'b0;
        cyc(2);
        rd(12'h021); chk("alarm fall", rdat, p ? {24'h0, m} : 32'h0);
        wr(12'h021, m);
      end
    end
    for (int k = 0; k < 5; k++) begin
      ev[k][15] <= 1'b1;
      cyc(1);
      ev[k][15] <= 1'b0;
      rd(12'h3E2); chk("viol set", rdat, 32'h20 >> k);
      wr(12'h3E2, 8'hFF);
    end
    rd(12'h3E2); chk("viol clear", rdat, 32'h0);
    fork
      wr(12'h022, 8'h20);
      begin
        cyc(2);
        ev[0][0] <= 1'b1;
        cyc(1);
        ev[0][0] <= 1'b0;
      end
    join
    rd(12'h022); chk("set wins", rdat, 32'h20);
    wr(12'h022, 8'h20);
    cnt_p <= 17'h00003;
    cyc(3);
    cnt_p <= 17'h00001;
    cyc(2);
    cnt_p <= 17'h0;
    wr(12'h02A, 8'h04);
    wr(12'h7EA, 8'h04);
    rd(12'h023); chk("tally", rdat, 32'h3);
    rd(12'h7E3); chk("ch0 tally", rdat, 32'h5);
    wr(12'h023, 8'hAA); chk("ro resp", {30'h0, resp}, 32'h0);
    rd(12'h023); chk("tally ro", rdat, 32'h3);
    cnt_p <= 17'h00002;
    cyc(65536);
    cnt_p <= 17'h0;
    rd(12'h022); chk("wrap flag", rdat, 32'h1);
    s_axi_wstrb <= 4'h0;
    wr(12'h022, 8'h01);
    s_axi_wstrb <= 4'hF;
    rd(12'h022); chk("strobe off", rdat, 32'h1);
    wr(12'h02A, 8'h04);
    rd(12'h023); chk("tally sat", rdat, 32'hFF);
    wr(12'h7EA, 8'h02);
    cnt_p <= 17'h00001;
    cyc(3 * round_len);
    rd(12'h7E3); chk("auto tally", rdat, round_len);
    cnt_p <= 17'h0;
    wr(12'h7EA, 8'h00);
    rd(12'h025); chk("rd unmapped", {30'h0, resp}, 32'h3);
    wr(12'h025, 8'h01); chk("wr unmapped", {30'h0, resp}, 32'h3);
    wr(12'h7F1, 8'h07);
    cyc(2); chk("irq on", {31'h0, irq}, 32'h1);
    rd(12'h7F0); chk("irq status", rdat, 32'h7);
    cyc(2); chk("irq off", {31'h0, irq}, 32'h0);
    ev[1][0] <= 1'b1;
    cyc(1);
    ev[1][0] <= 1'b0;
    cyc(3); chk("irq event", {31'h0, irq}, 32'h1);
    wr(12'h7F1, 8'h00);
    cyc(2); chk("irq masked", {31'h0, irq}, 32'h0);
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end
endmodule // tb

bind cafet_flags cafet_flags_checker #(.NUM_CH(NUM_CH)) chk_i (
  .clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .sys_side_alarm_state, .sys_bpv_event, .flag_int
);

`default_nettype wire
